// ### sst_pkg.sv
package sst_pkg;

  // ****************************************************************
  // Register offsets (byte addresses on the AXI4-Lite bus)
  // ****************************************************************
  localparam logic [7:0] OFF_FEAT   = 8'h00;
  localparam logic [7:0] OFF_COUNT  = 8'h04;
  localparam logic [7:0] OFF_LBA_LO = 8'h08;
  localparam logic [7:0] OFF_LBA_MD = 8'h0C;
  localparam logic [7:0] OFF_LBA_HI = 8'h10;
  localparam logic [7:0] OFF_CMD    = 8'h14;
  localparam logic [7:0] OFF_TFSTAT = 8'h18;
  localparam logic [7:0] OFF_DATA   = 8'h1C;
  localparam logic [7:0] OFF_INFO   = 8'h20;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Taskfile codes
  // ****************************************************************
  localparam logic [7:0] CMD_SMART   = 8'hB0;
  localparam logic [7:0] CMD_RLOG    = 8'h2F;
  localparam logic [7:0] CMD_WLOG    = 8'h3F;
  localparam logic [7:0] FEAT_SM_RD  = 8'hD5;
  localparam logic [7:0] LOG_STATUS  = 8'hE0;
  localparam logic [7:0] LOG_XFER    = 8'hE1;
  localparam logic [7:0] SIG_LO      = 8'h4F;
  localparam logic [7:0] SIG_HI      = 8'hC2;
  localparam logic [7:0] LBA_MD_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE     = 8'h01;
  localparam logic [7:0] CNT_EIGHT   = 8'h08;

  // ****************************************************************
  // Status page contents
  // ****************************************************************
  localparam logic [15:0] FMT_VER    = 16'h0003;
  localparam logic [15:0] SPEC_VER   = 16'h0001;
  localparam logic [15:0] EXT_OK     = 16'h0000;
  localparam logic [15:0] EXT_CNT    = 16'h0003;
  localparam logic [15:0] EXT_NO_CMD = 16'h000B;
  localparam logic [15:0] EXT_BUSY   = 16'hFFFF;
  localparam logic [7:0]  DS_ACTIVE  = 8'h00;
  localparam logic [7:0]  DS_SELF    = 8'h03;
  localparam logic [7:0]  DS_OFFLINE = 8'h04;
  localparam logic [7:0]  DS_SCT     = 8'h05;
  localparam logic [1:0]  PS_BAD     = 2'h3;
  localparam logic        FLAG_RST   = 1'b0;
  localparam logic [10:0] PAGE_WORDS = 11'h080;

  typedef struct packed {
    logic [7:0] feat;
    logic [7:0] count;
    logic [7:0] lba_lo;
    logic [7:0] lba_md;
    logic [7:0] lba_hi;
  } sst_tf_t;

  typedef struct packed {
    logic [31:0] flags;
    logic [7:0]  drv_state;
    logic [15:0] ext;
    logic [15:0] impl_ver;
  } sst_page_in_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PAGE = 4'b0010,
    ST_XRD  = 4'b0100,
    ST_XWR  = 4'b1000
  } sst_state_t;

endpackage

// ### sst_page.sv
`timescale 1ns/1ns
module sst_page (
  input  wire logic [6:0]            idx,
  input  wire sst_pkg::sst_page_in_t pin,
  output logic [31:0]                word
);

  // ****************************************************************
  // Status page word lookup, bytes little endian within each word
  // ****************************************************************
  always_comb
  begin
    case (idx)
      7'h00:   word = {pin.impl_ver, sst_pkg::FMT_VER};
      7'h01:   word = {pin.flags[15:0], sst_pkg::SPEC_VER};
      7'h02:   word = {8'h00, pin.drv_state, pin.flags[31:16]};
      7'h03:   word = {pin.ext, 16'h0000};
      default: word = 32'h0000_0000;
    endcase
  end

endmodule

// ### sst_top.sv
`timescale 1ns/1ns
// Summary of operation
// - Transfer data: log E1h, 2Fh read, 3Fh write.
// - Taskfile status reports only accept or reject.
// - Reading log E0h returns the status page.
// - Status request accepted even during background action.
// - Status request leaves power and background untouched.
// - SMART status: B0h, 4Fh, C2h, E0h, one sector.
// - Log status: 2Fh, E0h, middle zero, one sector.
// - Bytes 1:0 hold format version 0003h.
// - Bytes 3:2 hold implementation version.
// - Bytes 5:4 hold supported revision 0001h.
// - Flag bit 0 set after full write-same.
// - A user block write clears the flag, unless a full write-same completes in the same cycle.
// - Capacity change clears the flag, unless a full write-same completes in the same cycle.
// - Flag kept in non-volatile storage.
// - Byte 10 encodes drive state 0 to 5.
// - Bytes 15:14 extended status, FFFFh while SCT busy.
// - Extended status 0000h means no error.
// - Transfers need a prior transport command.
module sst_top #(
  parameter logic [15:0] IMPL_VER = 16'h0001
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        user_write,
  input  wire logic        cap_change,
  input  wire logic        ws_all_ok,
  input  wire logic        flag_nv_in,
  input  wire logic [1:0]  power_state,
  input  wire logic        self_test_busy,
  input  wire logic        offline_data_collection_busy,
  input  wire logic        sct_busy,
  input  wire logic        sct_done,
  input  wire logic [15:0] sct_ext,
  input  wire logic [31:0] xfer_rdata,
  output logic             flag_nv_out,
  output logic             sct_issue,
  output logic [31:0]      xd_wdata,
  output logic             xd_wvalid,
  output logic             xd_key,
  output logic             xd_rreq
);

  sst_pkg::sst_tf_t      tf_q;
  sst_pkg::sst_state_t   state_q;
  sst_pkg::sst_state_t   state_d;
  sst_pkg::sst_page_in_t page_in;
  logic [10:0] words_q;
  logic [10:0] words_d;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        aw_got_q;
  logic        w_got_q;
  logic        aw_rdy_q;
  logic        w_rdy_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        ar_rdy_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic        done_q;
  logic        err_q;
  logic        issued_q;
  logic        flag_q;
  logic        loaded_q;
  logic [7:0]  drv_state_q;
  logic [15:0] ext_q;
  logic        sct_bg_q;
  logic        sct_issue_q;
  logic [31:0] xd_wdata_q;
  logic        xd_wvalid_q;
  logic        xd_key_q;
  logic        xd_rreq_q;
  logic [31:0] page_word;

  // ****************************************************************
  // AXI4-Lite decode
  // ****************************************************************
  wire aw_hs   = s_axi_awvalid & aw_rdy_q;
  wire w_hs    = s_axi_wvalid & w_rdy_q;
  wire ar_hs   = s_axi_arvalid & ar_rdy_q;
  wire wr_fire = aw_got_q & w_got_q & ~bvalid_q;
  wire wr_map  = (aw_addr_q <= sst_pkg::OFF_INFO) & (aw_addr_q[1:0] == 2'h0);
  wire rd_map  = (s_axi_araddr <= sst_pkg::OFF_INFO) & (s_axi_araddr[1:0] == 2'h0);
  wire wr_b0   = wr_fire & w_strb_q[0];
  wire wr_cmd  = wr_b0 & (aw_addr_q == sst_pkg::OFF_CMD);
  wire wr_data = wr_fire & (aw_addr_q == sst_pkg::OFF_DATA);
  wire rd_data = ar_hs & (s_axi_araddr == sst_pkg::OFF_DATA);

  // ****************************************************************
  // Command decode
  // ****************************************************************
  wire [7:0] cmd     = w_data_q[7:0];
  wire mid_zero      = tf_q.lba_md == sst_pkg::LBA_MD_ZERO;
  wire cnt_one       = tf_q.count == sst_pkg::CNT_ONE;
  wire cnt_ok        = cnt_one | (tf_q.count == sst_pkg::CNT_EIGHT);
  wire is_smart_st   = (cmd == sst_pkg::CMD_SMART) & (tf_q.feat == sst_pkg::FEAT_SM_RD)
                     & (tf_q.lba_lo == sst_pkg::LOG_STATUS) & (tf_q.lba_md == sst_pkg::SIG_LO)
                     & (tf_q.lba_hi == sst_pkg::SIG_HI) & cnt_one;
  wire is_log_st     = (cmd == sst_pkg::CMD_RLOG) & (tf_q.lba_lo == sst_pkg::LOG_STATUS)
                     & mid_zero & cnt_one;
  wire is_key        = (cmd == sst_pkg::CMD_WLOG) & (tf_q.lba_lo == sst_pkg::LOG_STATUS)
                     & mid_zero & cnt_one;
  wire is_xrd        = (cmd == sst_pkg::CMD_RLOG) & (tf_q.lba_lo == sst_pkg::LOG_XFER)
                     & mid_zero;
  wire is_xwr        = (cmd == sst_pkg::CMD_WLOG) & (tf_q.lba_lo == sst_pkg::LOG_XFER)
                     & mid_zero;
  wire is_xfer       = is_xrd | is_xwr;
  wire xfer_ok       = is_xfer & issued_q & cnt_ok;
  wire is_status     = is_smart_st | is_log_st;
  wire accept        = is_status | is_key | xfer_ok;
  wire [10:0] xfer_w = {tf_q.count[3:0], 7'h00};

  // ****************************************************************
  // Data phase sequencing
  // ****************************************************************
  wire rd_phase  = (state_q == sst_pkg::ST_PAGE) | (state_q == sst_pkg::ST_XRD);
  wire beat      = rd_phase ? rd_data : ((state_q == sst_pkg::ST_XWR) & wr_data);
  wire last      = words_q == 11'h001;
  wire key_end   = (state_q == sst_pkg::ST_XWR) & beat & last & xd_key_q;
  wire [10:0] pg = sst_pkg::PAGE_WORDS - words_q;
  wire [6:0] idx = pg[6:0];

  // A new command always wins over an unfinished data phase, so a host that
  // gives up on a transfer can recover without a reset.
  always_comb
  begin
    state_d = state_q;
    words_d = words_q;
    if (wr_cmd)
    begin
      state_d = sst_pkg::ST_IDLE;
      if (is_status)
      begin
        state_d = sst_pkg::ST_PAGE;
        words_d = sst_pkg::PAGE_WORDS;
      end
      else if (is_key)
      begin
        state_d = sst_pkg::ST_XWR;
        words_d = sst_pkg::PAGE_WORDS;
      end
      else if (xfer_ok)
      begin
        state_d = is_xrd ? sst_pkg::ST_XRD : sst_pkg::ST_XWR;
        words_d = xfer_w;
      end
    end
    else
    begin
      case (state_q)
        sst_pkg::ST_IDLE: state_d = sst_pkg::ST_IDLE;
        sst_pkg::ST_PAGE, sst_pkg::ST_XRD, sst_pkg::ST_XWR:
        begin
          if (beat)
          begin
            words_d = words_q - 11'h001;
            if (last)
              state_d = sst_pkg::ST_IDLE;
          end
        end
        default: state_d = sst_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Page fields
  // ****************************************************************
  wire [15:0] ext_view = sct_bg_q ? sst_pkg::EXT_BUSY : ext_q;
  wire [7:0]  ps_code  = (power_state == sst_pkg::PS_BAD) ? sst_pkg::DS_ACTIVE
                       : {6'h00, power_state};
  wire [7:0]  ds_next  = sct_busy ? sst_pkg::DS_SCT
                       : offline_data_collection_busy ? sst_pkg::DS_OFFLINE
                       : self_test_busy ? sst_pkg::DS_SELF : ps_code;

  assign page_in = '{flags: {31'h0000_0000, flag_q}, drv_state: drv_state_q,
                     ext: ext_view, impl_ver: IMPL_VER};

  sst_page u_page (
    .idx  (idx),
    .pin  (page_in),
    .word (page_word)
  );

  wire drq = state_q != sst_pkg::ST_IDLE;
  wire [31:0] data_rd = (state_q == sst_pkg::ST_PAGE) ? page_word
                      : (state_q == sst_pkg::ST_XRD) ? xfer_rdata : 32'h0000_0000;
  wire [7:0] ra = s_axi_araddr;
  wire [31:0] rd_word =
      (ra == sst_pkg::OFF_FEAT)   ? {24'h00_0000, tf_q.feat}   :
      (ra == sst_pkg::OFF_COUNT)  ? {24'h00_0000, tf_q.count}  :
      (ra == sst_pkg::OFF_LBA_LO) ? {24'h00_0000, tf_q.lba_lo} :
      (ra == sst_pkg::OFF_LBA_MD) ? {24'h00_0000, tf_q.lba_md} :
      (ra == sst_pkg::OFF_LBA_HI) ? {24'h00_0000, tf_q.lba_hi} :
      (ra == sst_pkg::OFF_TFSTAT) ? {29'h0000_0000, drq, err_q, done_q} :
      (ra == sst_pkg::OFF_DATA)   ? data_rd :
      (ra == sst_pkg::OFF_INFO)   ? {ext_view, drv_state_q, 7'h00, flag_q} :
      32'h0000_0000;

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_rdy_q  <= 1'b0;
      w_rdy_q   <= 1'b0;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= sst_pkg::RESP_OKAY;
    end
    else
    begin
      aw_rdy_q <= aw_hs ? 1'b0 : (~aw_got_q & ~bvalid_q & ~wr_fire);
      w_rdy_q  <= w_hs ? 1'b0 : (~w_got_q & ~bvalid_q & ~wr_fire);
      if (aw_hs)
      begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_got_q <= 1'b0;
      if (w_hs)
      begin
        w_got_q  <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_got_q <= 1'b0;
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_map ? sst_pkg::RESP_OKAY : sst_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q  <= sst_pkg::RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end
    else
    begin
      ar_rdy_q <= ar_hs ? 1'b0 : ~rvalid_q;
      if (ar_hs)
      begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_word;
        rresp_q  <= rd_map ? sst_pkg::RESP_OKAY : sst_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Taskfile, command state and transfer stream
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tf_q        <= '0;
      state_q     <= sst_pkg::ST_IDLE;
      words_q     <= 11'h000;
      done_q      <= 1'b0;
      err_q       <= 1'b0;
      issued_q    <= 1'b0;
      ext_q       <= sst_pkg::EXT_OK;
      sct_issue_q <= 1'b0;
      xd_wdata_q  <= 32'h0000_0000;
      xd_wvalid_q <= 1'b0;
      xd_key_q    <= 1'b0;
      xd_rreq_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      words_q <= words_d;
      if (wr_b0 & (aw_addr_q == sst_pkg::OFF_FEAT))
        tf_q.feat <= w_data_q[7:0];
      if (wr_b0 & (aw_addr_q == sst_pkg::OFF_COUNT))
        tf_q.count <= w_data_q[7:0];
      if (wr_b0 & (aw_addr_q == sst_pkg::OFF_LBA_LO))
        tf_q.lba_lo <= w_data_q[7:0];
      if (wr_b0 & (aw_addr_q == sst_pkg::OFF_LBA_MD))
        tf_q.lba_md <= w_data_q[7:0];
      if (wr_b0 & (aw_addr_q == sst_pkg::OFF_LBA_HI))
        tf_q.lba_hi <= w_data_q[7:0];
      // Completion only says taken or refused; the action result goes to ext.
      if (wr_cmd)
      begin
        done_q <= 1'b1;
        err_q  <= ~accept;
        if (is_key)
          xd_key_q <= 1'b1;
        else if (xfer_ok)
          xd_key_q <= 1'b0;
      end
      if (wr_cmd & is_xfer & ~issued_q)
        ext_q <= sst_pkg::EXT_NO_CMD;
      else if (wr_cmd & is_xfer & ~cnt_ok)
        ext_q <= sst_pkg::EXT_CNT;
      else if (sct_done)
        ext_q <= sct_ext;
      if (key_end)
        issued_q <= 1'b1;
      sct_issue_q <= key_end;
      xd_wvalid_q <= (state_q == sst_pkg::ST_XWR) & beat;
      if ((state_q == sst_pkg::ST_XWR) & beat)
        xd_wdata_q <= w_data_q;
      xd_rreq_q <= (state_q == sst_pkg::ST_XRD) & beat;
    end
  end

  // ****************************************************************
  // Whole-media flag and drive state
  // ****************************************************************
  // The stored value is caught on the first edge after reset release, so a
  // power cycle restores what the non-volatile copy held.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flag_q      <= sst_pkg::FLAG_RST;
      loaded_q    <= 1'b0;
      drv_state_q <= sst_pkg::DS_ACTIVE;
      sct_bg_q    <= 1'b0;
    end
    else
    begin
      loaded_q    <= 1'b1;
      drv_state_q <= ds_next;
      sct_bg_q    <= sct_busy;
      if (~loaded_q)
        flag_q <= flag_nv_in;
      else if (ws_all_ok)
        flag_q <= 1'b1;
      else if (user_write | cap_change)
        flag_q <= 1'b0;
    end
  end

  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready  = w_rdy_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ar_rdy_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign flag_nv_out   = flag_q;
  assign sct_issue     = sct_issue_q;
  assign xd_wdata      = xd_wdata_q;
  assign xd_wvalid     = xd_wvalid_q;
  assign xd_key        = xd_key_q;
  assign xd_rreq       = xd_rreq_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  smart_status_a: assert property (wr_cmd & is_smart_st |=> state_q == sst_pkg::ST_PAGE & ~err_q)
    else $error("SMART status request not served");
  log_status_a: assert property (wr_cmd & is_log_st |=> state_q == sst_pkg::ST_PAGE & ~err_q)
    else $error("Log status request not served");
  busy_status_a: assert property (sct_busy & wr_cmd & is_status |=> done_q & ~err_q)
    else $error("Status refused while busy");
  status_quiet_a: assert property (state_q == sst_pkg::ST_PAGE |=> ~sct_issue_q & ~xd_rreq_q)
    else $error("Status read disturbed engine");
  xfer_read_a: assert property (wr_cmd & xfer_ok & is_xrd |=> state_q == sst_pkg::ST_XRD)
    else $error("Transfer read not started");
  xfer_gate_a: assert property (wr_cmd & is_xfer & ~issued_q |=> err_q & ext_q == sst_pkg::EXT_NO_CMD)
    else $error("Transfer without command accepted");
  accept_only_a: assert property (wr_cmd |=> done_q & (err_q == $past(~accept)))
    else $error("Taskfile status wrong");
  flag_set_a: assert property (loaded_q & ws_all_ok |=> flag_q ##1 $stable(flag_q) | ~loaded_q | $past(user_write | cap_change) | $past(ws_all_ok))
    else $error("Flag not set by write same");
  flag_clear_a: assert property (loaded_q & (user_write | cap_change) & ~ws_all_ok |=> ~flag_q)
    else $error("Flag not cleared");
  drive_code_a: assert property (sct_busy |=> drv_state_q == sst_pkg::DS_SCT)
    else $error("Drive state code wrong");
  ext_busy_a: assert property (sct_busy |=> ##1 page_in.ext == sst_pkg::EXT_BUSY | ~$past(sct_busy))
    else $error("Busy ext status missing");

endmodule

// ### sst_eng.sv
`timescale 1ns/1ns
module sst_eng #(
  parameter int BUSY = 900
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sct_issue,
  input  wire logic        xd_wvalid,
  input  wire logic        xd_key,
  input  wire logic [31:0] xd_wdata,
  input  wire logic        xd_rreq,
  output logic             sct_busy,
  output logic             sct_done,
  output logic [15:0]      sct_ext,
  output logic [31:0]      xfer_rdata
);
  // ****************************************************************
  // Command engine: runs an issued action long enough to be polled.
  // ****************************************************************
  int          left_q;
  int          kcnt;
  int          wcnt;
  int          icnt;
  logic [31:0] last;

  assign sct_busy = (left_q > 0);
  assign sct_ext  = sst_pkg::EXT_OK;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      left_q     <= 0;
      sct_done   <= 1'b0;
      xfer_rdata <= 32'hA5A5_0000;
      kcnt       <= 0;
      wcnt       <= 0;
      icnt       <= 0;
      last       <= 32'h0000_0000;
    end
    else
    begin
      sct_done <= (left_q == 1);
      if (sct_issue)
        left_q <= BUSY;
      else if (left_q > 0)
        left_q <= left_q - 1;
      if (xd_rreq)
        xfer_rdata <= xfer_rdata + 32'h0000_0001;
      if (xd_wvalid && xd_key)
        kcnt <= kcnt + 1;
      if (xd_wvalid && !xd_key)
        wcnt <= wcnt + 1;
      if (xd_wvalid)
        last <= xd_wdata;
      if (sct_issue)
        icnt <= icnt + 1;
    end
  end
endmodule

// ### sst_top_tb.sv
`timescale 1ns/1ns
module sst_top_tb;
  localparam logic [15:0] IMPL = 16'h5A3C;
  logic        clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, nv_in = 1'b1, stb = 1'b0, offline_data_collection = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, xrd, xwd;
  logic [1:0]  bresp, rresp, rr, pst = 2'h0;
  logic [2:0]  ev = 3'h0;
  logic        awready, wready, bvalid, arready, rvalid, nv_out, issue, wv, key, rreq;
  logic        sbusy, sdone;
  logic [15:0] sext;
  int          failures = 0;
  int          checks_done = 0;

  always #20 clk = ~clk;

  sst_top #(.IMPL_VER(IMPL)) DUT (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .user_write(ev[0]), .cap_change(ev[1]), .ws_all_ok(ev[2]), .flag_nv_in(nv_in),
    .power_state(pst), .self_test_busy(stb), .offline_data_collection_busy(offline_data_collection),
    .sct_busy(sbusy), .sct_done(sdone), .sct_ext(sext), .xfer_rdata(xrd),
    .flag_nv_out(nv_out), .sct_issue(issue), .xd_wdata(xwd), .xd_wvalid(wv),
    .xd_key(key), .xd_rreq(rreq));

  sst_eng ENG (.clk(clk), .rst(rst), .sct_issue(issue), .xd_wvalid(wv), .xd_key(key),
    .xd_wdata(xwd), .xd_rreq(rreq), .sct_busy(sbusy), .sct_done(sdone), .sct_ext(sext),
    .xfer_rdata(xrd));

  // ****************************************************************
  // Bus and compare tasks.
  // ****************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Ready and the answer are sampled at the rising edge that takes them.
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ta, tw, tb;
    logic [1:0] r;
    n = 0;
    tb = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb && n < 1000)
    begin
      @(posedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      n++;
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk(32'(r), 32'(er));
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    int n;
    logic ta, tr;
    n = 0;
    tr = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr && n < 1000)
    begin
      @(posedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      rr = rresp;
      n++;
      if (ta)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] f, c, lo, md, hi, op, input logic [2:0] st);
    logic [7:0] v [6];
    logic [31:0] r;
    v = '{f, c, lo, md, hi, op};
    for (int i = 0; i < 6; i++)
      axw(sst_pkg::OFF_FEAT + 8'(4 * i), {24'h0, v[i]}, sst_pkg::RESP_OKAY);
    axr(sst_pkg::OFF_TFSTAT, r);
    chk(r, {29'h0, st});
  endtask

  task automatic page(input logic [7:0] ds, input logic [15:0] ext, input logic fl);
    logic [31:0] r, e;
    for (int i = 0; i < 128; i++)
    begin
      axr(sst_pkg::OFF_DATA, r);
      e = (i == 0) ? {IMPL, 16'h0003} : (i == 1) ? {15'h0, fl, 16'h0001} :
          (i == 2) ? {8'h00, ds, 16'h0000} : (i == 3) ? {ext, 16'h0000} : 32'h0;
      chk(r, e);
    end
    axr(sst_pkg::OFF_TFSTAT, r);
    chk(r, 32'h0000_0001);
    chk(32'(rr), 32'(sst_pkg::RESP_OKAY));
  endtask

  task automatic give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic s_flag;
    logic [2:0] p [5];
    logic [31:0] r;
    p = '{3'h0, 3'h1, 3'h4, 3'h2, 3'h4};
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      ev <= p[i];
      @(posedge clk);
      ev <= 3'h0;
      axr(sst_pkg::OFF_INFO, r);
      chk(32'({r[0], nv_out}), 32'({2{i != 1 && i != 3}}));
    end
  endtask

  task automatic s_state;
    logic [31:0] r;
    for (int i = 0; i < 5; i++)
    begin
      pst <= (i < 3) ? 2'(i) : 2'h0;
      stb <= (i == 3);
      offline_data_collection <= (i == 4);
      axr(sst_pkg::OFF_INFO, r);
      chk(32'(r[15:8]), i);
    end
    pst <= 2'h1;
    stb <= 1'b0;
    offline_data_collection <= 1'b0;
  endtask

  task automatic s_status;
    logic [31:0] r;
    int n;
    n = 0;
    cmd(8'hD5, 8'h01, 8'hE0, 8'h4F, 8'hC2, 8'hB0, 3'b101);
    page(8'h01, 16'h0000, 1'b1);
    cmd(8'h00, 8'h01, 8'hE1, 8'h00, 8'h00, 8'h2F, 3'b011);
    axr(sst_pkg::OFF_INFO, r);
    chk(32'(r[31:16]), 32'h0000_000B);
    cmd(8'h00, 8'h01, 8'hE0, 8'h00, 8'h00, 8'h3F, 3'b101);
    for (int i = 0; i < 128; i++)
      axw(sst_pkg::OFF_DATA, 32'(i), sst_pkg::RESP_OKAY);
    // The engine counts a stream word one edge after the design presents it.
    @(posedge clk);
    chk(32'(ENG.kcnt * 2 + ENG.icnt), 32'd257);
    cmd(8'h00, 8'h01, 8'hE0, 8'h00, 8'h00, 8'h2F, 3'b101);
    page(8'h05, 16'hFFFF, 1'b1);
    while (sbusy && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    axr(sst_pkg::OFF_INFO, r);
    chk(32'(r[31:16]), 32'h0000_0000);
  endtask

  task automatic s_xfer;
    logic [31:0] r, e0;
    cmd(8'h00, 8'h01, 8'hE1, 8'h00, 8'h00, 8'h2F, 3'b101);
    e0 = xrd;
    for (int i = 0; i < 128; i++)
    begin
      axr(sst_pkg::OFF_DATA, r);
      chk(r, e0 + 32'(i));
    end
    cmd(8'h00, 8'h02, 8'hE1, 8'h00, 8'h00, 8'h2F, 3'b011);
    axr(sst_pkg::OFF_INFO, r);
    chk(32'(r[31:16]), 32'h0000_0003);
    cmd(8'h00, 8'h01, 8'hE1, 8'h00, 8'h00, 8'h3F, 3'b101);
    for (int i = 0; i < 128; i++)
      axw(sst_pkg::OFF_DATA, 32'hC0DE_0000 + 32'(i), sst_pkg::RESP_OKAY);
    @(posedge clk);
    chk(32'(ENG.wcnt), 32'd128);
    chk(ENG.last, 32'hC0DE_007F);
    axw(8'h24, 32'h0000_0000, sst_pkg::RESP_SLVERR);
    axr(8'h24, r);
    chk(32'(rr), 32'(sst_pkg::RESP_SLVERR));
    chk(r, 32'h0000_0000);
    axw(sst_pkg::OFF_TFSTAT, 32'h0000_0000, sst_pkg::RESP_OKAY);
    axr(sst_pkg::OFF_TFSTAT, r);
    chk(r, 32'h0000_0001);
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    s_flag;
    s_state;
    s_status;
    s_xfer;
    give_verdict;
  end

  initial
  begin
    #1_000_000;
    failures++;
    give_verdict;
  end
endmodule
